// *** epiu_pkg.sv ***
package epiu_pkg;

    // I/O register addresses; the mask register offset is a local choice.
    localparam logic [5:0] FLAGS_ADDR      = 6'h3a;
    localparam logic [5:0] MASK_ADDR       = 6'h3b;
    localparam logic [5:0] PCMSK_A_ADDR    = 6'h20;
    localparam logic [5:0] PCMSK_B_ADDR    = 6'h21;
    localparam logic [5:0] MCU_CONTROL_REGISTER_ADDR      = 6'h35;

    // Field positions in the mask and flag registers, and the sense field of the control register.
    localparam int         BIT_EXT_B       = 7;
    localparam int         BIT_EXT_A       = 6;
    localparam int         BIT_PC_HI       = 5;
    localparam int         BIT_PC_LO       = 4;
    localparam int         BIT_SENSE_HI    = 1;
    localparam int         BIT_SENSE_LO    = 0;

    // Reset values.
    localparam logic [7:0] FLAGS_RESET     = 8'h00;
    localparam logic [7:0] MASK_RESET      = 8'h00;
    localparam logic [7:0] PCMSK_RESET     = 8'h00;
    localparam logic [1:0] SENSE_RESET     = 2'h0;

    // Read masks: unimplemented bits read as zero.
    localparam logic [7:0] MASK_RD_MASK    = 8'hf0;
    localparam logic [7:0] FLAGS_RD_MASK   = 8'he0;

    // Sense modes.
    typedef enum logic [1:0]
    {
        SENSE_LEVEL   = 2'h0,
        SENSE_ANY     = 2'h1,
        SENSE_FALLING = 2'h2,
        SENSE_RISING  = 2'h3
    } epiu_sense_t;

    // Vector identifiers; one common vector serves both pin-change groups.
    typedef enum logic [1:0]
    {
        VEC_NONE  = 2'h0,
        VEC_EXT_A = 2'h1,
        VEC_EXT_B = 2'h3,
        VEC_PC    = 2'h2
    } epiu_vec_t;

    // Sleep modes that the core reports.
    typedef enum logic [1:0]
    {
        SLP_IDLE    = 2'h0,
        SLP_ADC_NR  = 2'h1,
        SLP_PWRDOWN = 2'h2,
        SLP_STANDBY = 2'h3
    } epiu_sleep_t;

endpackage : epiu_pkg

// *** epiu_sync.sv ***
`timescale 1ns/100ps

module epiu_sync
    import epiu_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : epiu_sync

// *** epiu_top.sv ***
`timescale 1ns/100ps

// How it works
// - Pin B interrupts need its enable and global.
// - Pin A interrupts need its enable and global.
// - Two sense bits select level or edge mode.
// - Pin activity triggers even when pin drives.
// - High group enable covers inputs 7..0, 15..12.
// - Low group enable covers inputs 11..8.
// - Both pin-change groups share one vector.
// - Mask low nibble always reads zero.
// - Pin B request sets flag bit seven.
// - Enabled set flag vectors to its handler.
// - Vector entry clears the serviced flag.
// - Writing one clears a flag; zero keeps.
// - Pin B flag stays zero in level mode.
// - Pin A flag behaves alike at bit six.
// - ADC-quiet sleep wakes on A level, pin-change.
// - Deep sleep wakes only on level, pin-change.

module epiu_top
    import epiu_pkg::*;
#(
    parameter int PC_WIDTH = 16
)
(
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                nrst,
    // I/O register port
    input  wire logic [5:0]          io_addr,
    input  wire logic                io_wr,
    input  wire logic                io_rd,
    input  wire logic [7:0]          io_wdata,
    output logic      [7:0]          io_rdata,
    // Core handshake
    input  wire logic                global_irq_enable,
    input  wire logic                vector_ack,
    input  wire logic                sleeping,
    input  wire logic [1:0]          sleep_mode,
    output logic                     irq_request,
    output logic      [1:0]          irq_vector,
    output logic                     wake_up,
    // Pins
    input  wire logic                ext_irq_a_pin,
    input  wire logic                ext_irq_b_pin,
    input  wire logic [PC_WIDTH-1:0] pin_change_input
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and edge detection

    logic [PC_WIDTH+1:0] pins_sync;
    logic [PC_WIDTH+1:0] pins_prev_reg;
    logic                ext_a_lvl;
    logic                ext_b_lvl;
    logic [PC_WIDTH-1:0] pc_lvl;

    // The pins are sampled at the input buffer, not after the direction
    // logic, so a pin driven as an output still raises requests.
    epiu_sync #(.WIDTH(PC_WIDTH + 2)) u_sync
    (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .async_in ({ext_irq_b_pin, ext_irq_a_pin, pin_change_input}),
        .sync_out (pins_sync)
    );

    assign pc_lvl    = pins_sync[PC_WIDTH-1:0];
    assign ext_a_lvl = pins_sync[PC_WIDTH];
    assign ext_b_lvl = pins_sync[PC_WIDTH+1];

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            pins_prev_reg <= '0;
        else
            pins_prev_reg <= pins_sync;
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers

    logic [7:0]          ext_irq_mask_reg;
    logic [7:0]          pin_change_mask_a_reg;
    logic [7:0]          pin_change_mask_b_reg;
    logic [1:0]          sense_reg;
    logic                wr_flags;

    assign wr_flags = io_wr && (io_addr == FLAGS_ADDR);

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ext_irq_mask_reg      <= MASK_RESET;
            pin_change_mask_a_reg <= PCMSK_RESET;
            pin_change_mask_b_reg <= PCMSK_RESET;
            sense_reg             <= SENSE_RESET;
        end
        else if (io_wr)
        begin
            case (io_addr)
                MASK_ADDR:    ext_irq_mask_reg <= io_wdata & MASK_RD_MASK;
                PCMSK_A_ADDR: pin_change_mask_a_reg <= io_wdata;
                PCMSK_B_ADDR: pin_change_mask_b_reg <= io_wdata;
                MCU_CONTROL_REGISTER_ADDR:   sense_reg <= io_wdata[BIT_SENSE_HI:BIT_SENSE_LO];
                default:      ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Trigger detection

    // Decodes a pin level and its previous value against the sense mode.
    function automatic logic sense_hit(input logic [1:0] mode,
                                       input logic       now_lvl,
                                       input logic       was_lvl);
        logic hit;
        hit = 1'b0;
        case (mode)
            SENSE_LEVEL:   hit = !now_lvl;
            SENSE_ANY:     hit = now_lvl != was_lvl;
            SENSE_FALLING: hit = was_lvl && !now_lvl;
            SENSE_RISING:  hit = !was_lvl && now_lvl;
            default:       hit = 1'b0;
        endcase
        return hit;
    endfunction : sense_hit

    logic        level_mode;
    logic        trig_a;
    logic        trig_b;
    logic [15:0] pc_unmasked;
    logic        pc_hi_change;
    logic        pc_lo_change;
    logic        pc_trig;
    logic [PC_WIDTH-1:0] pc_diff;

    assign level_mode = (sense_reg == SENSE_LEVEL);
    assign trig_a = sense_hit(sense_reg, ext_a_lvl,
                              pins_prev_reg[PC_WIDTH]);
    assign trig_b = sense_hit(sense_reg, ext_b_lvl,
                              pins_prev_reg[PC_WIDTH+1]);

    assign pc_diff     = pc_lvl ^ pins_prev_reg[PC_WIDTH-1:0];
    assign pc_unmasked = pc_diff[15:0]
                         & {pin_change_mask_b_reg, pin_change_mask_a_reg};
    // The high enable covers 7..0 and 15..12, the low one 11..8.
    assign pc_hi_change = ext_irq_mask_reg[BIT_PC_HI]
                          && (|pc_unmasked[7:0] || |pc_unmasked[15:12]);
    assign pc_lo_change = ext_irq_mask_reg[BIT_PC_LO]
                          && |pc_unmasked[11:8];
    assign pc_trig = pc_hi_change || pc_lo_change;

    ////////////////////////////////////////////////////////////////////////
    // Flags

    logic       flag_b_reg;
    logic       flag_a_reg;
    logic       pc_flag_reg;
    logic       ack_a;
    logic       ack_b;
    logic       ack_pc;

    assign ack_a  = vector_ack && (irq_vector == VEC_EXT_A);
    assign ack_b  = vector_ack && (irq_vector == VEC_EXT_B);
    assign ack_pc = vector_ack && (irq_vector == VEC_PC);

    // A new trigger in the clearing cycle keeps the flag set.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            flag_b_reg <= 1'b0;
        else if (level_mode)
            flag_b_reg <= 1'b0;
        else if (trig_b)
            flag_b_reg <= 1'b1;
        else if (ack_b || (wr_flags && io_wdata[BIT_EXT_B]))
            flag_b_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            flag_a_reg <= 1'b0;
        else if (level_mode)
            flag_a_reg <= 1'b0;
        else if (trig_a)
            flag_a_reg <= 1'b1;
        else if (ack_a || (wr_flags && io_wdata[BIT_EXT_A]))
            flag_a_reg <= 1'b0;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            pc_flag_reg <= 1'b0;
        else if (pc_trig)
            pc_flag_reg <= 1'b1;
        else if (ack_pc || (wr_flags && io_wdata[BIT_PC_HI]))
            pc_flag_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Dispatch

    logic       pend_a;
    logic       pend_b;
    logic       pend_pc;
    logic [1:0] vec_next;

    // In level mode the request follows the pin, not a flag.
    assign pend_a  = ext_irq_mask_reg[BIT_EXT_A]
                     && (level_mode ? !ext_a_lvl : flag_a_reg);
    assign pend_b  = ext_irq_mask_reg[BIT_EXT_B]
                     && (level_mode ? !ext_b_lvl : flag_b_reg);
    assign pend_pc = pc_flag_reg
                     && (ext_irq_mask_reg[BIT_PC_HI]
                         || ext_irq_mask_reg[BIT_PC_LO]);

    // Fixed priority: pin A, pin B, then the shared pin-change vector.
    always_comb
    begin
        vec_next = VEC_NONE;
        if (global_irq_enable)
        begin
            if (pend_a)
                vec_next = VEC_EXT_A;
            else if (pend_b)
                vec_next = VEC_EXT_B;
            else if (pend_pc)
                vec_next = VEC_PC;
        end
    end

    // The request drops for a cycle after each acknowledge so the core
    // never takes a flag that is already being cleared.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_request <= 1'b0;
            irq_vector  <= VEC_NONE;
        end
        else
        begin
            irq_request <= (vec_next != VEC_NONE) && !vector_ack;
            irq_vector  <= vector_ack ? VEC_NONE : vec_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake-up

    logic wake_next;

    // Edge triggers need the I/O clock, which stops in the deeper modes.
    always_comb
    begin
        wake_next = 1'b0;
        case (sleep_mode)
            SLP_IDLE:
                wake_next = pend_a || pend_b || pend_pc;
            SLP_ADC_NR:
                wake_next = (level_mode && pend_a) || pend_pc;
            default:
                wake_next = (level_mode && (pend_a || pend_b))
                            || pend_pc;
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            wake_up <= 1'b0;
        else
            wake_up <= sleeping && wake_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read back

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            io_rdata <= 8'h00;
        else if (io_rd)
        begin
            case (io_addr)
                MASK_ADDR:    io_rdata <= ext_irq_mask_reg & MASK_RD_MASK;
                FLAGS_ADDR:   io_rdata <= {flag_b_reg, flag_a_reg,
                                           pc_flag_reg, 5'h00};
                PCMSK_A_ADDR: io_rdata <= pin_change_mask_a_reg;
                PCMSK_B_ADDR: io_rdata <= pin_change_mask_b_reg;
                MCU_CONTROL_REGISTER_ADDR:   io_rdata <= {6'h00, sense_reg};
                default:      io_rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_ack_b;
        vector_ack && irq_vector == VEC_EXT_B && !trig_b;
    endsequence

    a_b_enable_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
        irq_vector == VEC_EXT_B |-> $past(ext_irq_mask_reg[BIT_EXT_B]))
        else $error("pin B vector without enable");
    a_a_enable_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
        irq_vector == VEC_EXT_A |-> $past(ext_irq_mask_reg[BIT_EXT_A]))
        else $error("pin A vector without enable");
    a_global_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
        irq_request |-> $past(global_irq_enable))
        else $error("request without global enable");
    a_mask_low_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(io_rd && io_addr == MASK_ADDR) |-> io_rdata[3:0] == 4'h0)
        else $error("mask low bits not zero");
    a_b_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst)
        trig_b && !level_mode |=> flag_b_reg)
        else $error("pin B flag not set");
    a_b_ack_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        s_ack_b |=> !flag_b_reg)
        else $error("pin B flag not cleared on entry");
    a_a_w1c_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_flags && io_wdata[BIT_EXT_A] && !trig_a |=> !flag_a_reg)
        else $error("pin A flag not cleared by write");
    a_level_flag_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        level_mode [*2] |-> !flag_a_reg && !flag_b_reg)
        else $error("flag set in level mode");
    a_pc_flag_set: assert property (@(posedge ref_clk) disable iff (!nrst)
        pc_trig |=> pc_flag_reg)
        else $error("pin-change flag not set");
    a_deep_no_edge: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(sleep_mode == SLP_PWRDOWN && !level_mode && !pend_pc)
        |-> !wake_up)
        else $error("edge woke deep sleep");

endmodule : epiu_top

// *** epiu_pins.sv ***
`timescale 1ns/100ps

module epiu_pins
(
    // Clock
    input  wire logic        ref_clk,
    // Commanded pin levels and settling delay in cycles
    input  wire logic [17:0] want,
    input  wire logic [3:0]  lag,
    // Pins
    output logic             ext_irq_a_pin,
    output logic             ext_irq_b_pin,
    output logic [15:0]      pin_change_input
);
    logic [3:0] wait_cnt;

    // Idle pins sit high, as with the port pull-ups on.
    initial
    begin
        {ext_irq_a_pin, ext_irq_b_pin, pin_change_input} = 18'h3ffff;
        wait_cnt = 4'h0;
    end

    // A slow source lets the new level appear only after lag cycles.
    always @(negedge ref_clk)
    begin
        if ({ext_irq_a_pin, ext_irq_b_pin, pin_change_input} === want)
            wait_cnt <= 4'h0;
        else if (wait_cnt >= lag)
            {ext_irq_a_pin, ext_irq_b_pin, pin_change_input} <= want;
        else
            wait_cnt <= wait_cnt + 4'h1;
    end
endmodule : epiu_pins

// *** epiu_top_tb.sv ***
`timescale 1ns/100ps

module epiu_top_tb
    import epiu_pkg::*;
;
    logic ref_clk = 0, nrst = 0, io_wr = 0, io_rd = 0;
    logic [5:0] io_addr = 6'h00;
    logic [7:0] io_wdata = 8'h00, io_rdata, d;
    logic global_irq_enable = 0, vector_ack = 0, sleeping = 0;
    logic [1:0] sleep_mode = 2'h0, irq_vector;
    logic irq_request, wake_up, pa, pb;
    logic [15:0] pc;
    logic [17:0] want = 18'h3ffff;
    logic [3:0] lag = 4'h0;
    int bad_count = 0, checked = 0, cycles = 0;

    always #25 ref_clk = ~ref_clk;

    epiu_pins epiu_pins_i (.ref_clk(ref_clk), .want(want), .lag(lag),
        .ext_irq_a_pin(pa), .ext_irq_b_pin(pb), .pin_change_input(pc));

    epiu_top epiu_top_i (.ref_clk(ref_clk), .nrst(nrst),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata),
        .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
        .sleeping(sleeping), .sleep_mode(sleep_mode),
        .irq_request(irq_request), .irq_vector(irq_vector),
        .wake_up(wake_up), .ext_irq_a_pin(pa), .ext_irq_b_pin(pb),
        .pin_change_input(pc));

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
    begin
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask : conclude

    task automatic chk(input string name, input logic [7:0] seen, exp);
    begin
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [7:0] v);
    begin
        @(negedge ref_clk);
        io_wr = 1;
        io_addr = a;
        io_wdata = v;
        @(negedge ref_clk);
        io_wr = 0;
    end
    endtask : wr

    task automatic rd(input logic [5:0] a);
    begin
        @(negedge ref_clk);
        io_rd = 1;
        io_addr = a;
        @(negedge ref_clk);
        io_rd = 0;
        d = io_rdata;
    end
    endtask : rd

    // Moves the pins and waits until the change has reached the flags.
    task automatic pins(input logic [17:0] v);
    begin
        @(negedge ref_clk);
        want = v;
        repeat (6 + lag) @(negedge ref_clk);
    end
    endtask : pins

    task automatic wait_irq(input logic [1:0] vec);
        int n;
    begin
        n = 0;
        while (irq_request !== 1'b1 && n < 20)
        begin
            @(negedge ref_clk);
            n++;
        end
        chk("irq_vector", {6'h00, irq_vector}, {6'h00, vec});
    end
    endtask : wait_irq

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(negedge ref_clk);
        nrst = 1;
        rd(FLAGS_ADDR); chk("flags", d, FLAGS_RESET);
        rd(MASK_ADDR); chk("mask", d, MASK_RESET);
        wr(MASK_ADDR, 8'hff);
        rd(MASK_ADDR); chk("mask", d, 8'hf0);
        rd(6'h3f); chk("unmapped", d, 8'h00);
        // Pin A, falling edge, slow source.
        wr(MCU_CONTROL_REGISTER_ADDR, 8'h02);
        wr(MASK_ADDR, 8'h40);
        global_irq_enable = 1;
        lag = 4'h5;
        pins(18'h1ffff);
        wait_irq(VEC_EXT_A);
        rd(FLAGS_ADDR); chk("flags", d, 8'h40);
        @(negedge ref_clk) vector_ack = 1;
        @(negedge ref_clk) vector_ack = 0;
        rd(FLAGS_ADDR); chk("flags", d, 8'h00);
        lag = 4'h0;
        pins(18'h3ffff);
        rd(FLAGS_ADDR); chk("rise", d, 8'h00);
        // Pin B, rising edge, global enable off first.
        wr(MCU_CONTROL_REGISTER_ADDR, 8'h03);
        wr(MASK_ADDR, 8'h80);
        global_irq_enable = 0;
        pins(18'h2ffff);
        pins(18'h3ffff);
        chk("irq_request", {7'h0, irq_request}, 8'h00);
        rd(FLAGS_ADDR); chk("flags", d, 8'h80);
        wr(FLAGS_ADDR, 8'h00);
        rd(FLAGS_ADDR); chk("flags", d, 8'h80);
        global_irq_enable = 1;
        wait_irq(VEC_EXT_B);
        wr(FLAGS_ADDR, 8'h80);
        rd(FLAGS_ADDR); chk("flags", d, 8'h00);
        chk("irq_request", {7'h0, irq_request}, 8'h00);
        // Either edge sets the flag.
        wr(MCU_CONTROL_REGISTER_ADDR, 8'h01);
        pins(18'h2ffff);
        rd(FLAGS_ADDR); chk("fall", d, 8'h80);
        wait_irq(VEC_EXT_B);
        @(negedge ref_clk) vector_ack = 1;
        @(negedge ref_clk) vector_ack = 0;
        rd(FLAGS_ADDR); chk("flags", d, 8'h00);
        wr(FLAGS_ADDR, 8'h80);
        pins(18'h3ffff);
        rd(FLAGS_ADDR); chk("rise", d, 8'h80);
        wr(FLAGS_ADDR, 8'h80);
        // Level mode: requests follow the pins, flags stay clear.
        wr(MCU_CONTROL_REGISTER_ADDR, 8'h00);
        wr(MASK_ADDR, 8'hc0);
        sleeping = 1;
        sleep_mode = SLP_PWRDOWN;
        pins(18'h0ffff);
        wait_irq(VEC_EXT_A);
        rd(FLAGS_ADDR); chk("flags", d, 8'h00);
        chk("wake_up", {7'h0, wake_up}, 8'h01);
        sleep_mode = SLP_ADC_NR;
        repeat (2) @(negedge ref_clk);
        chk("wake_up", {7'h0, wake_up}, 8'h01);
        pins(18'h2ffff);
        chk("wake_up", {7'h0, wake_up}, 8'h00);
        pins(18'h3ffff);
        chk("wake_up", {7'h0, wake_up}, 8'h00);
        // Edge flags do not wake from power-down.
        wr(MCU_CONTROL_REGISTER_ADDR, 8'h02);
        sleep_mode = SLP_PWRDOWN;
        pins(18'h1ffff);
        chk("wake_up", {7'h0, wake_up}, 8'h00);
        sleep_mode = SLP_STANDBY;
        repeat (2) @(negedge ref_clk);
        chk("wake_up", {7'h0, wake_up}, 8'h00);
        // Idle keeps the I/O clock, so an edge flag may wake it.
        sleep_mode = SLP_IDLE;
        repeat (2) @(negedge ref_clk);
        chk("wake_up", {7'h0, wake_up}, 8'h01);
        sleep_mode = SLP_PWRDOWN;
        pins(18'h3ffff);
        wr(FLAGS_ADDR, 8'hc0);
        // Pin-change groups share one vector.
        wr(MASK_ADDR, 8'h20);
        wr(PCMSK_A_ADDR, 8'h01);
        pins(18'h3fffe);
        wait_irq(VEC_PC);
        chk("wake_up", {7'h0, wake_up}, 8'h01);
        sleeping = 0;
        rd(FLAGS_ADDR); chk("flags", d, 8'h20);
        wr(FLAGS_ADDR, 8'h20);
        rd(FLAGS_ADDR); chk("flags", d, 8'h00);
        pins(18'h3fffc);
        rd(FLAGS_ADDR); chk("masked", d, 8'h00);
        wr(PCMSK_B_ADDR, 8'h10);
        pins(18'h3effc);
        rd(FLAGS_ADDR); chk("flags", d, 8'h20);
        wr(FLAGS_ADDR, 8'h20);
        wr(MASK_ADDR, 8'h10);
        wr(PCMSK_B_ADDR, 8'h01);
        pins(18'h3fefc);
        wait_irq(VEC_PC);
        rd(FLAGS_ADDR); chk("flags", d, 8'h20);
        conclude();
    end
endmodule : epiu_top_tb
